// >>> src/gpb_params.svh
// Purpose: Offsets, field positions, reset values for the port block
// Assumes: Avalon-MM byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef GPB_PARAMS_SVH
`define GPB_PARAMS_SVH
`define GPB_OFS_P8_DIR   4'h0
`define GPB_OFS_P8_DATA  4'h4
`define GPB_OFS_PB_DATA  4'h8
`define GPB_OFS_AN_SEL   4'hc
`define GPB_P8_LSB       5
`define GPB_P8_MSB       7
`define GPB_P8_RSV_MASK  8'h1f
`define GPB_DIR_RESET    3'h0
`define GPB_DATA_RESET   3'h0
`define GPB_ANSEL_RESET  5'h00
`define GPB_ANSEL_EXTDIS 4
`define GPB_ANSEL_SCAN   3
`endif

// >>> src/gpb_pkg.sv
// Purpose: Types shared by the port block
// Assumes: Nothing
// Notes:   Analog selection mirror of converter and detector bits
package gpb_pkg;
	typedef struct packed {
		logic       ext_compare_disable;
		logic       scan;
		logic [2:0] channel;
	} gpb_ansel_t;
	typedef enum logic [1:0] {
		GPB_IDLE,
		GPB_ACK
	} gpb_state_t;
endpackage

// >>> src/gpb_port.sv
// Purpose: Three-pin bidirectional port 8 and eight-pin input port B
// Assumes: Avalon-MM slave, 100 MHz clock, pins asynchronous
// Notes:   Each access answers one cycle after it is presented
//
// Implementation choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "gpb_params.svh"

module gpb_port
	import gpb_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic [3:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	input  wire logic [2:0]  p8_in,
	output logic      [2:0]  p8_out,
	output logic      [2:0]  p8_oe,
	input  wire logic [7:0]  pb_in
);
	logic [2:0]  dir;
	logic [2:0]  next_dir;
	logic [2:0]  data;
	logic [2:0]  next_data;
	gpb_ansel_t  ansel;
	gpb_ansel_t  next_ansel;
	gpb_state_t  state;
	gpb_state_t  next_state;
	logic [31:0] next_readdata;
	logic [2:0]  p8_meta;
	logic [2:0]  p8_sync;
	logic [7:0]  pb_meta;
	logic [7:0]  pb_sync;
	logic [7:0]  analog;
	logic [7:0]  p8_view;
	logic        take;

	// Two-stage synchronisers; first stage read only by the second
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			p8_meta <= 3'h0;
			p8_sync <= 3'h0;
			pb_meta <= 8'h00;
			pb_sync <= 8'h00;
		end else begin
			p8_meta <= p8_in;
			p8_sync <= p8_meta;
			pb_meta <= pb_in;
			pb_sync <= pb_meta;
		end
	end

	// Analog claim per port B pin
	always_comb begin
		analog = 8'h00;
		if (!ansel.scan) begin
			analog[ansel.channel] = 1'b1;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (i <= int'(ansel.channel[1:0])) begin
					analog[{ansel.channel[2], 2'(i)}] = 1'b1;
				end
			end
		end
		if (!ansel.ext_compare_disable) begin
			analog[7:6] = 2'b11;
		end
	end

	// Per-bit view of port 8 data on read
	always_comb begin
		p8_view = `GPB_P8_RSV_MASK;
		for (int i = 0; i < 3; i++) begin
			p8_view[`GPB_P8_LSB + i] = dir[i] ? data[i]
				: p8_sync[i];
		end
	end

	// A request is answered on the cycle after it appears
	assign take = (read || write) && (state == GPB_IDLE);

	always_comb begin
		next_state    = state;
		next_dir      = dir;
		next_data     = data;
		next_ansel    = ansel;
		next_readdata = readdata;
		case (state)
			GPB_IDLE: begin
				if (take) begin
					next_state    = GPB_ACK;
					next_readdata = 32'h0000_0000;
					if (!write) begin
						case (address)
							`GPB_OFS_P8_DATA:
								next_readdata = {24'h0, p8_view};
							`GPB_OFS_PB_DATA:
								next_readdata = {24'h0, pb_sync & ~analog};
							`GPB_OFS_AN_SEL:
								next_readdata = {27'h0, ansel};
							// Direction is write-only; unmapped reads zero
							default: next_readdata = 32'h0000_0000;
						endcase
					end
				end
			end
			// Write lands on the edge the master sees the answer
			GPB_ACK: begin
				next_state = GPB_IDLE;
				if (write) begin
					case (address)
						`GPB_OFS_P8_DIR:
							next_dir = writedata[`GPB_P8_MSB:`GPB_P8_LSB];
						`GPB_OFS_P8_DATA:
							next_data = writedata[`GPB_P8_MSB:`GPB_P8_LSB];
						`GPB_OFS_AN_SEL:
							next_ansel = writedata[4:0];
						default: ;
					endcase
				end
			end
			default: next_state = GPB_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state    <= GPB_IDLE;
			dir      <= `GPB_DIR_RESET;
			data     <= `GPB_DATA_RESET;
			ansel    <= `GPB_ANSEL_RESET;
			readdata <= 32'h0000_0000;
		end else begin
			state    <= next_state;
			dir      <= next_dir;
			data     <= next_data;
			ansel    <= next_ansel;
			readdata <= next_readdata;
		end
	end

	// Waitrequest low only in the answer cycle; pins from flops
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			waitrequest <= 1'b1;
			p8_out      <= 3'h0;
			p8_oe       <= 3'h0;
		end else begin
			waitrequest <= !take;
			p8_out      <= next_data;
			p8_oe       <= next_dir;
		end
	end
	// Port B has input pins only, no driver exists
endmodule

// >>> testbench/gpb_port_chk.sv
// Purpose: Bus and pin checks
// Assumes: Pins steady before reads
// Notes:   Bound below
`timescale 1ns/10ps
module gpb_chk(
	input logic        clock,
	input logic        rst_n,
	input logic [3:0]  address,
	input logic        read,
	input logic        write,
	input logic [31:0] writedata,
	input logic [31:0] readdata,
	input logic        waitrequest,
	input logic [2:0]  p8_in,
	input logic [2:0]  p8_out,
	input logic [2:0]  p8_oe,
	input logic [7:0]  pb_in
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	wire rk = read && !waitrequest;
	wire wk = write && !waitrequest;
	wire [2:0] wh = writedata[7:5];
	ans_a: assert property ((read|write)&&waitrequest |=> !waitrequest)
		else $error("ack");
	one_a: assert property (!waitrequest |=> waitrequest) else $error("one");
	dir_a: assert property (wk&&address==4'h0 |=> p8_oe==$past(wh))
		else $error("dir");
	dat_a: assert property (wk&&address==4'h4 |=> p8_out==$past(wh))
		else $error("dat");
	rsv_a: assert property (rk&&address==4'h4 |-> readdata[4:0]==5'h1f)
		else $error("rsv");
	out_a: assert property (rk&&address==4'h4 |->
		((readdata[7:5]^p8_out)&p8_oe)==3'h0) else $error("out");
	inp_a: assert property (rk&&address==4'h4 |->
		((readdata[7:5]^$past(p8_in,3))&~p8_oe)==3'h0) else $error("inp");
	pbk_a: assert property (rk&&address==4'h8 |->
		(readdata[7:0]&~$past(pb_in,3))==8'h0) else $error("pb");
	cover property (wk);
	cover property (rk&&address==4'h8);
	cover property (rk&&address==4'h4);
endmodule
bind gpb_port gpb_chk chk(.clock,.rst_n,.address,.read,.write,.writedata,
	.readdata,.waitrequest,.p8_in,.p8_out,.p8_oe,.pb_in);

// >>> testbench/gpb_pins.sv
// Purpose: Port 8 board pins
// Assumes: Bench sets undriven levels
// Notes:   Device drive wins
`timescale 1ns/10ps
module gpb_pins(
	input logic [2:0]  p8_out,
	input logic [2:0]  p8_oe,
	input logic [2:0]  ext8,
	output logic [2:0] p8_in
);
	assign p8_in = p8_oe&p8_out | ~p8_oe&ext8;
endmodule

// >>> testbench/tb_top.sv
// Purpose: Self-checking bench
// Assumes: Reads queue expected bytes
// Notes:   Pins settle before reads
`timescale 1ns/10ps
module tb_top;
	logic clock=0, rst_n=0, read=0, write=0, waitrequest;
	logic [3:0] address=4'h0;
	logic [31:0] writedata=32'h0, lf=32'ha044, r, readdata;
	logic [2:0] ext8=3'h5, p8_in, p8_out, p8_oe;
	logic [7:0] pb_in=8'hff, q[$];
	int err_total=0, checked=0;
	always #5 clock = ~clock;
	gpb_port uut(.clock,.rst_n,.address,.read,.write,.writedata,.readdata,
		.waitrequest,.p8_in,.p8_out,.p8_oe,.pb_in);
	gpb_pins pins(.p8_out,.p8_oe,.ext8,.p8_in);
	function automatic logic [31:0] rnd();
		lf = {lf[30:0], lf[31]^lf[21]^lf[1]^lf[0]};
		return lf;
	endfunction
	function automatic logic [7:0] an(input logic [4:0] s);
		return (s[3] ? ((8'h2<<s[1:0])-8'h1)<<{s[2],2'h0} : 8'h1<<s[2:0])
			| (s[4] ? 8'h0 : 8'hc0);
	endfunction
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e) begin
			err_total++;
			$display("wrong value readdata exp %h got %h", e, s);
		end
	endtask
	task automatic acc(input logic [3:0] a, input logic w, input logic [31:0] d);
		address <= a;
		writedata <= d;
		write <= w;
		read <= !w;
		do @(posedge clock); while (waitrequest !== 1'b0);
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		q.push_back(e);
		acc(a, 1'b0, 32'h0);
	endtask
	task automatic tally_and_finish;
		$display("errors %0d checks %0d", err_total, checked);
		if (err_total == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	always @(posedge clock) if (read && waitrequest === 1'b0) begin
		chk(readdata[7:0], q.pop_front());
	end
	initial begin
		#100us;
		err_total++;
		tally_and_finish;
	end
	initial begin
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		rd(4'h0, 8'h0);
		rd(4'h1, 8'h0);
		rd(4'h4, 8'hbf);
		rd(4'h8, 8'h3e);
		for (int i = 0; i < 32; i++) begin
			r = rnd();
			pb_in <= r[7:0];
			ext8 <= r[10:8];
			acc(4'hc, 1'b1, {27'h0, i[4:0]});
			acc(4'h4, 1'b1, r);
			acc(4'h0, 1'b1, {24'h0, r[15:13], 5'h0});
			repeat (5) @(posedge clock);
			rd(4'h8, r[7:0] & ~an(i[4:0]));
			rd(4'h4, {r[7:5]&r[15:13] | r[10:8]&~r[15:13], 5'h1f});
		end
		tally_and_finish;
	end
endmodule
